/* rtl/pex_pkg.sv */
// Purpose: Shared constants and types of the two-group port expander slave.
// Assumes: 8-bit port groups, a 7-bit serial slave address, MSB first.
// Notes: Event words carry link-side happenings into the system clock domain.
package pex_pkg;
  localparam int DATA_W = 8;
  localparam int EV_W = 2;
  localparam int FIFO_W = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int EV_LSB = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [1:0] EV_ADDR = 2'h0;
  localparam logic [1:0] EV_RDREQ = 2'h1;
  localparam logic [1:0] EV_WRITE = 2'h2;
  localparam logic [1:0] EV_STOP = 2'h3;
  localparam int EVB_GRP_OD = 1;
  localparam int EVB_RW = 0;
  localparam logic [2:0] ADDR_TOP_OD = 3'h6;
  localparam logic [2:0] ADDR_TOP_PP = 3'h5;
  localparam logic [7:0] OD_LATCH_RST = 8'hFF;
  localparam logic [7:0] PP_LATCH_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_WR = 8'h08,
    ST_WACK = 8'h10,
    ST_RD = 8'h20,
    ST_MACK = 8'h40,
    ST_IGN = 8'h80
  } pex_link_st_e;
endpackage : pex_pkg

/* rtl/pex_top.sv */
// Purpose: Serial slave of a two-group port expander, with link and system domains.
// Assumes: clk_link free-running, much faster than SCL; SCL/SDA oversampled.
// Notes: Link events cross by an async FIFO; read bytes return by toggle handshake.
`timescale 1ns/1ps

module pex_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_r;
  logic [AW:0] wgray_r;
  logic [AW:0] rbin_r;
  logic [AW:0] rgray_r;
  logic [AW:0] wg_m_r;
  logic [AW:0] wg_s_r;
  logic [AW:0] rg_m_r;
  logic [AW:0] rg_s_r;
  logic [AW:0] wbin_nxt;
  logic [AW:0] rbin_nxt;
  logic wr_en;
  logic rd_en;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // Full when write pointer is one lap ahead of the synced read pointer
  assign wr_ready = (wgray_r != {~rg_s_r[AW:AW-1], rg_s_r[AW-2:0]});
  assign rd_valid = (rgray_r != wg_s_r);
  assign wr_en = wr_valid & wr_ready;
  assign rd_en = rd_valid & rd_ready;
  assign wbin_nxt = wbin_r + {{AW{1'b0}}, 1'b1};
  assign rbin_nxt = rbin_r + {{AW{1'b0}}, 1'b1};
  assign rd_data = mem[rbin_r[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_r <= '0;
      wgray_r <= '0;
    end else if (wr_en) begin
      wbin_r <= wbin_nxt;
      wgray_r <= to_gray(wbin_nxt);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      rg_m_r <= '0;
      rg_s_r <= '0;
    end else begin
      rg_m_r <= rgray_r;
      rg_s_r <= rg_m_r;
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_r <= '0;
      rgray_r <= '0;
    end else if (rd_en) begin
      rbin_r <= rbin_nxt;
      rgray_r <= to_gray(rbin_nxt);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      wg_m_r <= '0;
      wg_s_r <= '0;
    end else begin
      wg_m_r <= wgray_r;
      wg_s_r <= wg_m_r;
    end
  end
endmodule : pex_fifo

module pex_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_link,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] address_select_low,
  input wire logic [1:0] address_select_high,
  input wire logic [7:0] open_drain_port_group_in,
  output logic [7:0] open_drain_port_group_out,
  output logic [7:0] open_drain_port_group_oe,
  input wire logic [7:0] push_pull_port_group_in,
  output logic [7:0] push_pull_port_group_out,
  output logic alert_n_out,
  output logic alert_n_oe
);
  // Reset release, one copy per domain
  logic rst_sys_m_r;
  logic rst_sys_n_r;
  logic rst_lnk_m_r;
  logic rst_lnk_n_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sys_m_r <= 1'b0;
      rst_sys_n_r <= 1'b0;
    end else begin
      rst_sys_m_r <= 1'b1;
      rst_sys_n_r <= rst_sys_m_r;
    end
  end

  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      rst_lnk_m_r <= 1'b0;
      rst_lnk_n_r <= 1'b0;
    end else begin
      rst_lnk_m_r <= 1'b1;
      rst_lnk_n_r <= rst_lnk_m_r;
    end
  end

  // ---------------- Link domain ----------------
  logic scl_m_r, scl_s_r, scl_q_r;
  logic sda_m_r, sda_s_r, sda_q_r;
  logic [3:0] strap_m_r;
  logic [3:0] strap_s_r;
  logic [3:0] strap_r;
  logic strap_done_r;
  logic [1:0] strap_age_r;
  logic rsp_m_r, rsp_s_r;
  logic ack_tgl_r;
  logic [7:0] tx_r;
  pex_pkg::pex_link_st_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tsh_r;
  logic sda_oe_r;
  logic grp_od_r;
  logic rw_r;
  logic in_xfer_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic hit_od, hit_pp;
  logic fifo_wr_valid, fifo_wr_ready;
  logic [pex_pkg::FIFO_W-1:0] fifo_wr_data;
  logic resp_tgl_r;
  logic [7:0] resp_data_r;

  always_ff @(posedge clk_link or negedge rst_lnk_n_r) begin
    if (!rst_lnk_n_r) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_q_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_q_r <= sda_s_r;
    end
  end

  // Straps caught once after reset release, then frozen
  always_ff @(posedge clk_link or negedge rst_lnk_n_r) begin
    if (!rst_lnk_n_r) begin
      strap_m_r <= 4'h0;
      strap_s_r <= 4'h0;
      strap_r <= 4'h0;
      strap_done_r <= 1'b0;
      strap_age_r <= 2'h0;
    end else begin
      strap_m_r <= {address_select_high, address_select_low};
      strap_s_r <= strap_m_r;
      strap_age_r <= {strap_age_r[0], 1'b1};
      // Wait until both sync stages hold real pin levels
      if (strap_age_r[1] && !strap_done_r) begin
        strap_r <= strap_s_r;
        strap_done_r <= 1'b1;
      end
    end
  end

  assign scl_rise = scl_s_r & ~scl_q_r;
  assign scl_fall = ~scl_s_r & scl_q_r;
  assign start_det = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
  assign hit_od = (sh_r[7:5] == pex_pkg::ADDR_TOP_OD) && (sh_r[4:1] == strap_r);
  assign hit_pp = (sh_r[7:5] == pex_pkg::ADDR_TOP_PP) && (sh_r[4:1] == strap_r);

  always_ff @(posedge clk_link or negedge rst_lnk_n_r) begin
    if (!rst_lnk_n_r) begin
      st_r <= pex_pkg::ST_IDLE;
      cnt_r <= pex_pkg::CNT_ZERO;
      sh_r <= pex_pkg::BYTE_ZERO;
      tsh_r <= pex_pkg::BYTE_ZERO;
      sda_oe_r <= 1'b0;
      grp_od_r <= 1'b0;
      rw_r <= 1'b0;
    end else if (start_det) begin
      st_r <= pex_pkg::ST_ADDR;
      cnt_r <= pex_pkg::CNT_ZERO;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= pex_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        pex_pkg::ST_ADDR: begin
          if (scl_rise && cnt_r != pex_pkg::BITS_PER_BYTE) begin
            sh_r <= {sh_r[6:0], sda_s_r};
            cnt_r <= cnt_r + pex_pkg::CNT_ONE;
          end else if (scl_fall && cnt_r == pex_pkg::BITS_PER_BYTE) begin
            cnt_r <= pex_pkg::CNT_ZERO;
            if ((hit_od || hit_pp) && fifo_wr_ready) begin
              st_r <= pex_pkg::ST_AACK;
              sda_oe_r <= 1'b1;
              grp_od_r <= hit_od;
              rw_r <= sh_r[0];
            end else begin
              st_r <= pex_pkg::ST_IGN;
            end
          end
        end
        pex_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              st_r <= pex_pkg::ST_RD;
              sda_oe_r <= ~tx_r[7];
              tsh_r <= {tx_r[6:0], 1'b0};
              cnt_r <= pex_pkg::CNT_ONE;
            end else begin
              st_r <= pex_pkg::ST_WR;
              sda_oe_r <= 1'b0;
              cnt_r <= pex_pkg::CNT_ZERO;
            end
          end
        end
        pex_pkg::ST_WR: begin
          if (scl_rise && cnt_r != pex_pkg::BITS_PER_BYTE) begin
            sh_r <= {sh_r[6:0], sda_s_r};
            cnt_r <= cnt_r + pex_pkg::CNT_ONE;
          end else if (scl_fall && cnt_r == pex_pkg::BITS_PER_BYTE) begin
            cnt_r <= pex_pkg::CNT_ZERO;
            // A full event queue refuses the byte with a NACK
            if (fifo_wr_ready) begin
              st_r <= pex_pkg::ST_WACK;
              sda_oe_r <= 1'b1;
            end else begin
              st_r <= pex_pkg::ST_IGN;
            end
          end
        end
        pex_pkg::ST_WACK: begin
          if (scl_fall) begin
            st_r <= pex_pkg::ST_WR;
            sda_oe_r <= 1'b0;
          end
        end
        pex_pkg::ST_RD: begin
          if (scl_fall) begin
            if (cnt_r == pex_pkg::BITS_PER_BYTE) begin
              st_r <= pex_pkg::ST_MACK;
              sda_oe_r <= 1'b0;
            end else begin
              sda_oe_r <= ~tsh_r[7];
              tsh_r <= {tsh_r[6:0], 1'b0};
              cnt_r <= cnt_r + pex_pkg::CNT_ONE;
            end
          end
        end
        pex_pkg::ST_MACK: begin
          if (scl_rise && sda_s_r) begin
            st_r <= pex_pkg::ST_IGN;
          end else if (scl_fall) begin
            st_r <= pex_pkg::ST_RD;
            sda_oe_r <= ~tx_r[7];
            tsh_r <= {tx_r[6:0], 1'b0};
            cnt_r <= pex_pkg::CNT_ONE;
          end
        end
        pex_pkg::ST_IDLE, pex_pkg::ST_IGN: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          st_r <= pex_pkg::ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link or negedge rst_lnk_n_r) begin
    if (!rst_lnk_n_r) begin
      in_xfer_r <= 1'b0;
    end else if (stop_det) begin
      in_xfer_r <= 1'b0;
    end else if (st_r == pex_pkg::ST_AACK) begin
      in_xfer_r <= 1'b1;
    end
  end

  // Event pushes are mutually exclusive by bus timing
  always_comb begin
    fifo_wr_valid = 1'b0;
    fifo_wr_data = {pex_pkg::EV_STOP, pex_pkg::BYTE_ZERO};
    if (stop_det && in_xfer_r) begin
      fifo_wr_valid = 1'b1;
    end else if (st_r == pex_pkg::ST_AACK && scl_rise) begin
      fifo_wr_valid = 1'b1;
      fifo_wr_data = {pex_pkg::EV_ADDR, 6'h00, grp_od_r, rw_r};
    end else if (st_r == pex_pkg::ST_WR && scl_fall && cnt_r == pex_pkg::BITS_PER_BYTE) begin
      fifo_wr_valid = 1'b1;
      fifo_wr_data = {pex_pkg::EV_WRITE, sh_r};
    end else if (st_r == pex_pkg::ST_MACK && scl_rise && !sda_s_r) begin
      fifo_wr_valid = 1'b1;
      fifo_wr_data = {pex_pkg::EV_RDREQ, pex_pkg::BYTE_ZERO};
    end
  end

  // Read byte arrives by toggle; data is stable while the toggle travels
  always_ff @(posedge clk_link or negedge rst_lnk_n_r) begin
    if (!rst_lnk_n_r) begin
      rsp_m_r <= 1'b0;
      rsp_s_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      tx_r <= pex_pkg::BYTE_ZERO;
    end else begin
      rsp_m_r <= resp_tgl_r;
      rsp_s_r <= rsp_m_r;
      if (rsp_s_r != ack_tgl_r) begin
        tx_r <= resp_data_r;
        ack_tgl_r <= rsp_s_r;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_r;

  // ---------------- System domain ----------------
  logic fifo_rd_valid, fifo_rd_ready;
  logic [pex_pkg::FIFO_W-1:0] fifo_rd_data;
  logic ack_m_r, ack_s_r;
  logic [7:0] od_m_r, od_s_r, pp_m_r, pp_s_r;
  logic [7:0] snap_r, flags_r, flags_prev_r, od_latch_r, pp_latch_r, diff;
  logic cur_od_r, rd_idx_r, hold_r, alert_oe_r;
  logic take, ev_addr, ev_rdreq, ev_write, ev_stop;
  logic grp_od_now, od_sample, send_req, send_flags;
  logic [7:0] resp_byte;

  pex_fifo #(.WIDTH(pex_pkg::FIFO_W), .DEPTH(pex_pkg::FIFO_DEPTH)) u_evq (
    .wr_clk(clk_link),
    .wr_rst_n(rst_lnk_n_r),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(fifo_wr_data),
    .rd_clk(clk_sys),
    .rd_rst_n(rst_sys_n_r),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data)
  );

  always_ff @(posedge clk_sys or negedge rst_sys_n_r) begin
    if (!rst_sys_n_r) begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      // Released pins idle high; avoids a false change at reset
      od_m_r <= pex_pkg::OD_LATCH_RST;
      od_s_r <= pex_pkg::OD_LATCH_RST;
      pp_m_r <= pex_pkg::BYTE_ZERO;
      pp_s_r <= pex_pkg::BYTE_ZERO;
    end else begin
      ack_m_r <= ack_tgl_r;
      ack_s_r <= ack_m_r;
      od_m_r <= open_drain_port_group_in;
      od_s_r <= od_m_r;
      pp_m_r <= push_pull_port_group_in;
      pp_s_r <= pp_m_r;
    end
  end

  // Queue drain stalls while a read byte is still in flight to the link
  assign fifo_rd_ready = (resp_tgl_r == ack_s_r);
  assign take = fifo_rd_valid & fifo_rd_ready;
  assign ev_addr = take && fifo_rd_data[9:pex_pkg::EV_LSB] == pex_pkg::EV_ADDR;
  assign ev_rdreq = take && fifo_rd_data[9:pex_pkg::EV_LSB] == pex_pkg::EV_RDREQ;
  assign ev_write = take && fifo_rd_data[9:pex_pkg::EV_LSB] == pex_pkg::EV_WRITE;
  assign ev_stop = take && fifo_rd_data[9:pex_pkg::EV_LSB] == pex_pkg::EV_STOP;
  assign grp_od_now = ev_addr ? fifo_rd_data[pex_pkg::EVB_GRP_OD] : cur_od_r;
  assign od_sample = (ev_addr & fifo_rd_data[pex_pkg::EVB_GRP_OD]) | (ev_rdreq & cur_od_r & ~rd_idx_r);
  assign send_flags = ev_rdreq & cur_od_r & rd_idx_r;
  assign send_req = (ev_addr & fifo_rd_data[pex_pkg::EVB_RW]) | ev_rdreq;
  assign resp_byte = send_flags ? flags_prev_r : (grp_od_now ? od_s_r : pp_s_r);
  assign diff = od_s_r ^ snap_r;

  always_ff @(posedge clk_sys or negedge rst_sys_n_r) begin
    if (!rst_sys_n_r) begin
      cur_od_r <= 1'b0;
      rd_idx_r <= 1'b0;
    end else if (ev_addr) begin
      cur_od_r <= fifo_rd_data[pex_pkg::EVB_GRP_OD];
      rd_idx_r <= fifo_rd_data[pex_pkg::EVB_GRP_OD] & fifo_rd_data[pex_pkg::EVB_RW];
    end else if (ev_rdreq && cur_od_r) begin
      rd_idx_r <= ~rd_idx_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n_r) begin
    if (!rst_sys_n_r) begin
      hold_r <= 1'b0;
    end else if (ev_stop) begin
      hold_r <= 1'b0;
    end else if (ev_addr && fifo_rd_data[pex_pkg::EVB_GRP_OD] && fifo_rd_data[pex_pkg::EVB_RW]) begin
      hold_r <= 1'b1;
    end
  end

  // New snapshot equals the sampled input, so the clear loses no change
  always_ff @(posedge clk_sys or negedge rst_sys_n_r) begin
    if (!rst_sys_n_r) begin
      snap_r <= pex_pkg::OD_LATCH_RST;
      flags_r <= pex_pkg::BYTE_ZERO;
      flags_prev_r <= pex_pkg::BYTE_ZERO;
    end else if (od_sample) begin
      snap_r <= od_s_r;
      flags_prev_r <= flags_r | diff;
      flags_r <= pex_pkg::BYTE_ZERO;
    end else begin
      flags_r <= flags_r | diff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n_r) begin
    if (!rst_sys_n_r) begin
      od_latch_r <= pex_pkg::OD_LATCH_RST;
      pp_latch_r <= pex_pkg::PP_LATCH_RST;
    end else if (ev_write) begin
      if (cur_od_r) begin
        od_latch_r <= fifo_rd_data[7:0];
      end else begin
        pp_latch_r <= fifo_rd_data[7:0];
      end
    end
  end

  // Alert only pulls low; release leaves the line to any pull-up
  always_ff @(posedge clk_sys or negedge rst_sys_n_r) begin
    if (!rst_sys_n_r) begin
      alert_oe_r <= 1'b0;
    end else begin
      alert_oe_r <= (|flags_r) & ~hold_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n_r) begin
    if (!rst_sys_n_r) begin
      resp_tgl_r <= 1'b0;
      resp_data_r <= pex_pkg::BYTE_ZERO;
    end else if (send_req) begin
      resp_tgl_r <= ~resp_tgl_r;
      resp_data_r <= resp_byte;
    end
  end

  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert_oe_r;
  assign open_drain_port_group_out = pex_pkg::BYTE_ZERO;
  assign open_drain_port_group_oe = ~od_latch_r;
  assign push_pull_port_group_out = pp_latch_r;
endmodule : pex_top

/* verif/pex_top_chk.sv */
// Purpose: Port-level checks of the two-group expander slave.
// Assumes: SCL phases last many link clocks; ports resolved in the bench.
// Notes: Bound to pex_top after the module.
`timescale 1ns/1ps

module pex_top_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_link,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] open_drain_port_group_out,
  input wire logic [7:0] open_drain_port_group_oe,
  input wire logic [7:0] push_pull_port_group_out,
  input wire logic alert_n_out,
  input wire logic alert_n_oe
);
  sequence oe_up;
    $rose(sda_oe);
  endsequence
  sequence ack_win;
    sda_oe && !scl_in;
  endsequence

  oe_hold_a:
    assert property (@(posedge clk_link) disable iff (!rst_b) oe_up |-> sda_oe [*8])
    else $error("sda drive too short");
  oe_rise_a:
    assert property (@(posedge clk_link) disable iff (!rst_b) oe_up |-> !scl_in && !$past(scl_in))
    else $error("sda driven outside scl low");
  sda_hi_a:
    assert property (@(posedge clk_link) disable iff (!rst_b)
      scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  latch_ack_a:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(push_pull_port_group_out) || $changed(open_drain_port_group_oe) |-> ack_win)
    else $error("port latch moved outside ack");
  alert_rel_a:
    assert property (@(posedge clk_sys) disable iff (!rst_b) $fell(alert_n_oe) |-> sda_oe && scl_in)
    else $error("alert released outside address ack");
  rst_quiet_a:
    assert property (@(posedge clk_sys) disable iff (!rst_b) $rose(rst_b) |->
      !sda_oe && !alert_n_oe && push_pull_port_group_out == 8'h00 && open_drain_port_group_oe == 8'h00)
    else $error("outputs not quiet after reset");
  sda_low_a:
    assert property (@(posedge clk_link) disable iff (!rst_b) sda_out == 1'b0)
    else $error("sda not open drain");
  pins_low_a:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      open_drain_port_group_out == 8'h00 && alert_n_out == 1'b0)
    else $error("open drain pin drives high");
endmodule : pex_top_chk

bind pex_top pex_top_chk u_chk (.clk_sys, .rst_b, .clk_link, .scl_in, .sda_out, .sda_oe,
  .open_drain_port_group_out, .open_drain_port_group_oe, .push_pull_port_group_out,
  .alert_n_out, .alert_n_oe);

/* verif/pex_master_model.sv */
// Purpose: Behavioural serial bus master facing the expander.
// Assumes: Pull-up on SDA resolved by the bench; SCL idles high.
// Notes: slow stretches every SCL low phase except the one before a stop.
`timescale 1ns/1ps

module pex_master_model (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  localparam int TL = 1300;
  localparam int TH = 600;
  int slow = 0;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic put_bit(input logic v);
    #200 sda_rel = v;
    #(TL - 200 + slow) scl = 1'b1;
    #TH scl = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic v);
    sda_rel = 1'b1;
    #(TL + slow) scl = 1'b1;
    #(TH / 2) v = sda;
    #(TH / 2) scl = 1'b0;
  endtask : get_bit
  task automatic start;
    #TH sda_rel = 1'b0;
    #TH scl = 1'b0;
  endtask : start
  task automatic stop;
    #200 sda_rel = 1'b0;
    #TL scl = 1'b1;
    #TH sda_rel = 1'b1;
    #TH;
  endtask : stop
  task automatic send(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(nack);
  endtask : send
  task automatic recv(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
  endtask : recv
endmodule : pex_master_model

/* verif/pex_top_test.sv */
// Purpose: Self-checking bench of the expander slave.
// Assumes: Pull-up on SDA; open-drain pins high unless pulled low.
// Notes: Pin levels and flags are tracked by the bench.
`timescale 1ns/1ps

module pex_top_test;
  logic clk_sys, clk_link, rst_b, scl, sda_rel, sda_oe, sda_out, alert_n_out, alert_n_oe, nk;
  logic [1:0] sel_lo, sel_hi;
  logic [7:0] od_ext, od_lat, pp_lat, od_oe, od_out, pp_out, f_m, f_v, snap, flg, b;
  logic [6:0] a_od, a_pp;
  int n_fail, n_tests, seed;
  wire sda = sda_rel & ~sda_oe;
  wire [7:0] od_in = od_ext & ~od_oe;
  wire [7:0] pp_in = (pp_out & ~f_m) | (f_v & f_m);

  pex_top DUT (.clk_sys, .rst_b, .clk_link, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .address_select_low(sel_lo), .address_select_high(sel_hi), .open_drain_port_group_in(od_in),
    .open_drain_port_group_out(od_out), .open_drain_port_group_oe(od_oe),
    .push_pull_port_group_in(pp_in), .push_pull_port_group_out(pp_out), .alert_n_out, .alert_n_oe);
  pex_master_model M (.scl, .sda_rel, .sda);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #15 clk_link = ~clk_link;
  end

  function automatic logic [7:0] od_pins(input logic [7:0] e, input logic [7:0] l);
    return e & l;
  endfunction : od_pins
  function automatic logic [7:0] pp_pins(input logic [7:0] o, input logic [7:0] m, input logic [7:0] v);
    return (o & ~m) | (v & m);
  endfunction : pp_pins

  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic ws(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : ws
  task automatic chk_alert(input string what);
    check({7'h00, alert_n_oe}, {7'h00, |flg}, what);
  endtask : chk_alert
  task automatic upd;
    flg = flg | (snap ^ od_pins(od_ext, od_lat));
  endtask : upd
  task automatic addr(input logic [6:0] a, input logic rw);
    M.start();
    M.send({a, rw}, nk);
    ws(5);
    check({7'h00, nk}, 8'h00, "address ack");
  endtask : addr

  task automatic wr(input logic od, input logic [7:0] v, input logic [7:0] w);
    logic [7:0] d[2];
    d[0] = v;
    d[1] = w;
    addr(od ? a_od : a_pp, 1'b0);
    if (od) begin
      snap = od_pins(od_ext, od_lat);
      flg = 8'h00;
    end
    chk_alert("alert at write address");
    for (int i = 0; i < 2; i++) begin
      M.send(d[i], nk);
      ws(20);
      check({7'h00, nk}, 8'h00, "data ack");
      if (od) od_lat = d[i];
      else pp_lat = d[i];
      check(od_oe, ~od_lat, "open drain latch");
      check(pp_out, pp_lat, "push pull latch");
      upd();
    end
    M.stop();
    ws(20);
    chk_alert("alert after write");
  endtask : wr

  task automatic rd_od(input int nb);
    logic [7:0] prev;
    addr(a_od, 1'b1);
    snap = od_pins(od_ext, od_lat);
    prev = flg;
    flg = 8'h00;
    chk_alert("alert at read address");
    M.recv(b);
    check(b, snap, "port byte");
    @(posedge clk_sys) od_ext <= od_ext ^ (8'($random(seed)) | 8'h01);
    ws(10);
    upd();
    check({7'h00, alert_n_oe}, 8'h00, "alert during read");
    M.put_bit(nb == 1);
    if (nb > 1) begin
      M.recv(b);
      check(b, prev, "flag byte");
      M.put_bit(nb == 2);
    end
    if (nb == 3) begin
      snap = od_pins(od_ext, od_lat);
      flg = 8'h00;
      M.recv(b);
      check(b, snap, "resampled port byte");
      M.put_bit(1'b1);
    end
    M.stop();
    ws(20);
    chk_alert("alert at stop");
  endtask : rd_od

  task automatic rd_pp;
    addr(a_pp, 1'b1);
    for (int i = 0; i < 2; i++) begin
      M.recv(b);
      check(b, pp_pins(pp_lat, f_m, f_v), "pin readback");
      @(posedge clk_sys) f_v <= 8'($random(seed));
      ws(10);
      M.put_bit(i == 1);
    end
    M.stop();
    ws(20);
    chk_alert("alert after pin read");
  endtask : rd_pp

  initial begin
    #900000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    seed = 32'h0438CB5F;
    n_fail = 0;
    n_tests = 0;
    rst_b = 1'b0;
    sel_lo = 2'($random(seed));
    sel_hi = 2'($random(seed));
    a_od = {3'b110, sel_hi, sel_lo};
    a_pp = {3'b101, sel_hi, sel_lo};
    od_ext = 8'hFF;
    od_lat = 8'hFF;
    pp_lat = 8'h00;
    f_m = 8'h00;
    f_v = 8'h00;
    snap = 8'hFF;
    flg = 8'h00;
    ws(12);
    rst_b <= 1'b1;
    ws(60);
    check(pp_out, 8'h00, "push pull reset");
    chk_alert("alert after reset");
    M.start();
    M.send({3'b111, sel_hi, sel_lo, 1'b1}, nk);
    M.stop();
    check({7'h00, nk}, 8'h01, "foreign address");
    for (int i = 0; i < 3; i++) begin
      M.slow = (i == 1) ? 600 : 0;
      @(posedge clk_sys);
      f_m <= 8'($random(seed));
      f_v <= 8'($random(seed));
      wr(1'b1, 8'($random(seed)), 8'hFF);
      wr(1'b0, 8'($random(seed)), 8'($random(seed)));
      @(posedge clk_sys) od_ext <= 8'($random(seed));
      ws(10);
      upd();
      chk_alert("alert on input change");
      rd_od(i + 1);
      rd_pp();
    end
    give_verdict();
  end
endmodule : pex_top_test
